// ===== hul_pkg.sv
// Shared constants, register map and state types of the host serial link.
//
// Contract
// - One start, eight data LSB first, one stop.
// - Full duplex with data and flow-control lines.
// - Two-line or four-line operation is selectable.
// - Programmable bit rate, 9600 to 921600 bps.
// - At least three character times between messages.
// - Message gap length is adjustable by software.
// - Detect character timeout, overrun and framing errors.
// - Alternate port can swap transmit and receive pins.
// - Wake the host before sending data.
// - Pins act as serial lines only once assigned.
// - Low reset input acts asynchronously by level.
// - Internal reset held until oscillator settle timer expires.
// - Transmit only while clear-to-send low, at character boundaries.
// - Request-to-send low while receiver can accept data.
// - Framing error when stop bit samples zero.
// - Receive timeout defaults to twelve character times.
package hul_pkg;
    localparam int          ADDR_W        = 8;
    localparam int          DATA_W        = 32;
    localparam int          CHAR_BITS     = 10;
    localparam int          DATA_BITS     = 8;
    // Register offsets (byte addresses).
    localparam logic [7:0]  OFF_CTRL      = 8'h00;
    localparam logic [7:0]  OFF_BAUD      = 8'h04;
    localparam logic [7:0]  OFF_GAP       = 8'h08;
    localparam logic [7:0]  OFF_TXDATA    = 8'h0C;
    localparam logic [7:0]  OFF_RXDATA    = 8'h10;
    localparam logic [7:0]  OFF_STATUS    = 8'h14;
    // Control bits.
    localparam int          CTRL_EN       = 0;
    localparam int          CTRL_FOUR     = 1;
    localparam int          CTRL_SWAP     = 2;
    localparam int          CTRL_WAKE     = 3;
    localparam int          CTRL_W        = 4;
    // Field positions.
    localparam int          BAUD_OSR_LSB  = 16;
    localparam int          GAP_RXTO_LSB  = 8;
    localparam int          GAP_WAKE_LSB  = 16;
    localparam int          TX_EOM_BIT    = 8;
    localparam int          ST_TO         = 0;
    localparam int          ST_OVR        = 1;
    localparam int          ST_FRM        = 2;
    localparam int          ST_RXFULL     = 3;
    localparam int          ST_TXFULL     = 4;
    localparam int          ST_TXACT      = 5;
    // Reset values.
    localparam logic [3:0]  CTRL_RST      = 4'h0;
    localparam logic [15:0] DIV_RST       = 16'h001F;
    localparam logic [4:0]  OSR_RST       = 5'h0E;
    localparam logic [7:0]  TXGAP_RST     = 8'h03;
    localparam logic [7:0]  RXTO_RST      = 8'h0C;
    localparam logic [7:0]  WAKE_RST      = 8'h01;
    // Oscillator settle time.
    localparam int          CLK_MHZ       = 50;
    localparam int          SETTLE_US     = 1000;
    localparam int          SETTLE_CYCLES = SETTLE_US * CLK_MHZ;

    typedef enum logic [3:0] {
        TX_IDLE = 4'b0001,
        TX_WAKE = 4'b0010,
        TX_SEND = 4'b0100,
        TX_GAP  = 4'b1000
    } hul_txst_t;

    typedef enum logic [3:0] {
        RX_IDLE  = 4'b0001,
        RX_START = 4'b0010,
        RX_DATA  = 4'b0100,
        RX_STOP  = 4'b1000
    } hul_rxst_t;
endpackage

// ===== hul_tx.sv
// Serial character transmitter.
`timescale 1ns/1ns
`default_nettype none
module hul_tx (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rst,
    // Timing
    input  wire logic       sampleTick,
    input  wire logic [4:0] osr,
    // Character request
    input  wire logic       start,
    input  wire logic [7:0] data,
    output logic            busy,
    output logic            done,
    // Serial line
    output logic            line
);
    logic [9:0] shiftReg;
    logic [3:0] bitCnt;
    logic [4:0] phase;

    // Frame shifter: each bit lasts osr sample ticks, timed from the start request.
    always_ff @(posedge clk) begin
        if (rst) begin
            line     <= 1'b1;
            busy     <= 1'b0;
            done     <= 1'b0;
            shiftReg <= 10'h3FF;
            bitCnt   <= 4'h0;
            phase    <= 5'h00;
        end else begin
            done <= 1'b0;
            if (!busy && start) begin
                shiftReg <= {1'b1, data, 1'b0};
                line     <= 1'b0;
                busy     <= 1'b1;
                bitCnt   <= 4'h0;
                phase    <= 5'h00;
            end else if (busy && sampleTick) begin
                if (phase == osr - 5'h01) begin
                    phase <= 5'h00;
                    if (bitCnt == 4'(hul_pkg::CHAR_BITS - 1)) begin
                        busy <= 1'b0;
                        done <= 1'b1;
                        line <= 1'b1;
                    end else begin
                        bitCnt   <= bitCnt + 4'h1;
                        shiftReg <= {1'b1, shiftReg[9:1]};
                        line     <= shiftReg[1];
                    end
                end else begin
                    phase <= phase + 5'h01;
                end
            end
        end
    end
endmodule // hul_tx
`default_nettype wire

// ===== hul_rx.sv
// Serial character receiver with mid-bit sampling.
`timescale 1ns/1ns
`default_nettype none
module hul_rx (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rst,
    // Timing
    input  wire logic       sampleTick,
    input  wire logic [4:0] osr,
    // Serial line
    input  wire logic       line,
    // Character result
    output logic            valid,
    output logic            frameErr,
    output logic [7:0]      data
);
    hul_pkg::hul_rxst_t state;
    logic [4:0]         phase;
    logic [2:0]         bitCnt;

    // Start detection, data capture and stop check.
    always_ff @(posedge clk) begin
        if (rst) begin
            state    <= hul_pkg::RX_IDLE;
            phase    <= 5'h00;
            bitCnt   <= 3'h0;
            data     <= 8'h00;
            valid    <= 1'b0;
            frameErr <= 1'b0;
        end else begin
            valid    <= 1'b0;
            frameErr <= 1'b0;
            if (sampleTick) begin
                unique case (state)
                    hul_pkg::RX_IDLE: begin
                        phase <= 5'h00;
                        if (!line) begin
                            state <= hul_pkg::RX_START;
                        end
                    end
                    hul_pkg::RX_START: begin
                        if (phase == {1'b0, osr[4:1]}) begin
                            phase  <= 5'h00;
                            bitCnt <= 3'h0;
                            state  <= line ? hul_pkg::RX_IDLE : hul_pkg::RX_DATA;
                        end else begin
                            phase <= phase + 5'h01;
                        end
                    end
                    hul_pkg::RX_DATA: begin
                        if (phase == osr - 5'h01) begin
                            phase <= 5'h00;
                            data  <= {line, data[7:1]};
                            if (bitCnt == 3'(hul_pkg::DATA_BITS - 1)) begin
                                state <= hul_pkg::RX_STOP;
                            end else begin
                                bitCnt <= bitCnt + 3'h1;
                            end
                        end else begin
                            phase <= phase + 5'h01;
                        end
                    end
                    hul_pkg::RX_STOP: begin
                        if (phase == osr - 5'h01) begin
                            valid    <= line;
                            frameErr <= !line;
                            state    <= hul_pkg::RX_IDLE;
                        end else begin
                            phase <= phase + 5'h01;
                        end
                    end
                    default: state <= hul_pkg::RX_IDLE;
                endcase
            end
        end
    end
endmodule // hul_rx
`default_nettype wire

// ===== hul_top.sv
// Host serial link: register port, reset timer, message pacing and pin routing.
`timescale 1ns/1ns
`default_nettype none
module hul_top #(
    parameter int SETTLE_CYCLES        = hul_pkg::SETTLE_CYCLES,
    parameter bit alternate_serial_port = 1'b1
) (
    // Clock and resets
    input  wire logic        clk,
    input  wire logic        srst,
    input  wire logic        power_on_reset_n_in,
    // Register port
    input  wire logic [7:0]  busAddr,
    input  wire logic [31:0] busWdata,
    input  wire logic        busWr,
    input  wire logic        busRd,
    output logic      [31:0] busRdata,
    // Serial pin A (transmit unless swapped)
    input  wire logic        pinAIn,
    output logic             pinAOut,
    output logic             pinAOe,
    // Serial pin B (receive unless swapped)
    input  wire logic        pinBIn,
    output logic             pinBOut,
    output logic             pinBOe,
    // Flow control and host wake
    input  wire logic        clear_to_send_n_in,
    output logic             request_to_send_n_out,
    output logic             hostWakeOut
);
    localparam int SW = $clog2(SETTLE_CYCLES + 1);

    // Address match shared by read and write decode.
    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        hit = (a == off);
    endfunction

    logic          porMeta, porSync, settled;
    logic [SW-1:0] settleCnt;
    logic          rst;
    logic [3:0]    ctrlReg;
    logic [15:0]   divReg;
    logic [4:0]    osrReg;
    logic [7:0]    txGapReg, rxToReg, wakeReg;
    logic [7:0]    txHold, rxHold;
    logic          txEom, txFull, rxFull;
    logic          errTo, errOvr, errFrm;
    logic [15:0]   sampleCnt;
    logic [4:0]    bitPhase;
    logic          sampleTick, bitTick;
    hul_pkg::hul_txst_t txState;
    logic [11:0]   txCnt, rxCnt;
    logic          rxArmed, txStart, txBusy, txDone, txLine;
    logic          rxValid, rxFrm, rxLine, swapEff, ctsOk, toHit;
    logic [7:0]    rxData;
    logic          wrCtrl, wrBaud, wrGap, wrTx, wrSt, rdRx;

    // Reset input is caught asynchronously; the settle timer restarts on each assertion.
    always_ff @(posedge clk or negedge power_on_reset_n_in) begin
        if (!power_on_reset_n_in) begin
            porMeta   <= 1'b0;
            porSync   <= 1'b0;
            settleCnt <= '0;
            settled   <= 1'b0;
        end else begin
            porMeta <= 1'b1;
            porSync <= porMeta;
            if (porSync && !settled) begin
                settleCnt <= settleCnt + SW'(1);
                settled   <= (settleCnt == SW'(SETTLE_CYCLES - 1));
            end
        end
    end

    // Internal reset covers the oscillator settle time.
    assign rst = srst || !settled;

    assign wrCtrl  = busWr && hit(busAddr, hul_pkg::OFF_CTRL);
    assign wrBaud  = busWr && hit(busAddr, hul_pkg::OFF_BAUD);
    assign wrGap   = busWr && hit(busAddr, hul_pkg::OFF_GAP);
    assign wrTx    = busWr && hit(busAddr, hul_pkg::OFF_TXDATA);
    assign wrSt    = busWr && hit(busAddr, hul_pkg::OFF_STATUS);
    assign rdRx    = busRd && hit(busAddr, hul_pkg::OFF_RXDATA);
    assign swapEff = alternate_serial_port && ctrlReg[hul_pkg::CTRL_SWAP];
    assign ctsOk   = !ctrlReg[hul_pkg::CTRL_FOUR] || !clear_to_send_n_in;
    assign toHit   = (rxCnt == 12'(rxToReg) * 12'(hul_pkg::CHAR_BITS));

    // Configuration registers.
    always_ff @(posedge clk) begin
        if (rst) begin
            ctrlReg  <= hul_pkg::CTRL_RST;
            divReg   <= hul_pkg::DIV_RST;
            osrReg   <= hul_pkg::OSR_RST;
            txGapReg <= hul_pkg::TXGAP_RST;
            rxToReg  <= hul_pkg::RXTO_RST;
            wakeReg  <= hul_pkg::WAKE_RST;
        end else begin
            if (wrCtrl) begin
                ctrlReg <= busWdata[hul_pkg::CTRL_W-1:0];
            end
            if (wrBaud) begin
                divReg <= busWdata[15:0];
                osrReg <= busWdata[hul_pkg::BAUD_OSR_LSB +: 5];
            end
            if (wrGap) begin
                txGapReg <= busWdata[7:0];
                rxToReg  <= busWdata[hul_pkg::GAP_RXTO_LSB +: 8];
                wakeReg  <= busWdata[hul_pkg::GAP_WAKE_LSB +: 8];
            end
        end
    end

    // Rate divider: sample tick every divReg cycles, bit tick every osrReg samples.
    always_ff @(posedge clk) begin
        if (rst) begin
            sampleCnt  <= 16'h0000;
            bitPhase   <= 5'h00;
            sampleTick <= 1'b0;
            bitTick    <= 1'b0;
        end else begin
            sampleTick <= (sampleCnt == divReg - 16'h0001);
            sampleCnt  <= (sampleCnt >= divReg - 16'h0001) ? 16'h0000 : sampleCnt + 16'h0001;
            bitTick    <= 1'b0;
            if (sampleTick) begin
                bitTick  <= (bitPhase == osrReg - 5'h01);
                bitPhase <= (bitPhase >= osrReg - 5'h01) ? 5'h00 : bitPhase + 5'h01;
            end
        end
    end

    // Transmit holding register: a write while full is ignored.
    always_ff @(posedge clk) begin
        if (rst) begin
            txHold <= 8'h00;
            txEom  <= 1'b0;
            txFull <= 1'b0;
        end else if (txStart) begin
            txFull <= 1'b0;
        end else if (wrTx && !txFull) begin
            txHold <= busWdata[7:0];
            txEom  <= busWdata[hul_pkg::TX_EOM_BIT];
            txFull <= 1'b1;
        end
    end

    // Message pacing: host wake, clear-to-send check per character, gap after each message.
    always_ff @(posedge clk) begin
        if (rst) begin
            txState     <= hul_pkg::TX_IDLE;
            txCnt       <= 12'h000;
            txStart     <= 1'b0;
            hostWakeOut <= 1'b0;
        end else begin
            txStart <= 1'b0;
            unique case (txState)
                hul_pkg::TX_IDLE: begin
                    if (txFull && !txStart && ctrlReg[hul_pkg::CTRL_EN]) begin
                        if (ctrlReg[hul_pkg::CTRL_WAKE] && !hostWakeOut) begin
                            hostWakeOut <= 1'b1;
                            txCnt       <= 12'(wakeReg) * 12'(hul_pkg::CHAR_BITS);
                            txState     <= hul_pkg::TX_WAKE;
                        end else if (ctsOk) begin
                            txStart <= 1'b1;
                            txState <= hul_pkg::TX_SEND;
                        end
                    end
                end
                hul_pkg::TX_WAKE: begin
                    if (txCnt == 12'h000) begin
                        txState <= hul_pkg::TX_IDLE;
                    end else if (bitTick) begin
                        txCnt <= txCnt - 12'h001;
                    end
                end
                hul_pkg::TX_SEND: begin
                    if (txDone) begin
                        if (txEom) begin
                            txCnt       <= 12'(txGapReg) * 12'(hul_pkg::CHAR_BITS) + 12'h001;
                            hostWakeOut <= 1'b0;
                            txState     <= hul_pkg::TX_GAP;
                        end else begin
                            txState <= hul_pkg::TX_IDLE;
                        end
                    end
                end
                hul_pkg::TX_GAP: begin
                    if (txCnt == 12'h000) begin
                        txState <= hul_pkg::TX_IDLE;
                    end else if (bitTick) begin
                        txCnt <= txCnt - 12'h001;
                    end
                end
                default: txState <= hul_pkg::TX_IDLE;
            endcase
        end
    end

    hul_tx u_tx (
        .clk        (clk),
        .rst        (rst),
        .sampleTick (sampleTick),
        .osr        (osrReg),
        .start      (txStart),
        .data       (txHold),
        .busy       (txBusy),
        .done       (txDone),
        .line       (txLine)
    );

    // Receive line follows the pin routing; idle high until pins are assigned.
    assign rxLine = !ctrlReg[hul_pkg::CTRL_EN] ? 1'b1 : (swapEff ? pinAIn : pinBIn);

    hul_rx u_rx (
        .clk        (clk),
        .rst        (rst),
        .sampleTick (sampleTick),
        .osr        (osrReg),
        .line       (rxLine),
        .valid      (rxValid),
        .frameErr   (rxFrm),
        .data       (rxData)
    );

    // Receive holding register; a character arriving with a read keeps the holder full.
    always_ff @(posedge clk) begin
        if (rst) begin
            rxHold <= 8'h00;
            rxFull <= 1'b0;
        end else if (rxValid && (!rxFull || rdRx)) begin
            rxHold <= rxData;
            rxFull <= 1'b1;
        end else if (rdRx) begin
            rxFull <= 1'b0;
        end
    end

    // Inter-character timer, armed by each received character.
    always_ff @(posedge clk) begin
        if (rst) begin
            rxCnt   <= 12'h000;
            rxArmed <= 1'b0;
        end else if (rxValid || rxFrm) begin
            rxCnt   <= 12'h000;
            rxArmed <= 1'b1;
        end else if (rxArmed && toHit) begin
            rxArmed <= 1'b0;
        end else if (rxArmed && bitTick) begin
            rxCnt <= rxCnt + 12'h001;
        end
    end

    // Sticky error flags, write one to clear; a new event wins over the clear.
    always_ff @(posedge clk) begin
        if (rst) begin
            errTo  <= 1'b0;
            errOvr <= 1'b0;
            errFrm <= 1'b0;
        end else begin
            errTo  <= (rxArmed && toHit) || (errTo && !(wrSt && busWdata[hul_pkg::ST_TO]));
            errOvr <= (rxValid && rxFull && !rdRx) || (errOvr && !(wrSt && busWdata[hul_pkg::ST_OVR]));
            errFrm <= rxFrm || (errFrm && !(wrSt && busWdata[hul_pkg::ST_FRM]));
        end
    end

    // Registered pin drive; pins stay released until software assigns them.
    always_ff @(posedge clk) begin
        if (rst) begin
            pinAOut               <= 1'b1;
            pinAOe                <= 1'b0;
            pinBOut               <= 1'b1;
            pinBOe                <= 1'b0;
            request_to_send_n_out <= 1'b1;
        end else begin
            pinAOut               <= txLine;
            pinBOut               <= txLine;
            pinAOe                <= ctrlReg[hul_pkg::CTRL_EN] && !swapEff;
            pinBOe                <= ctrlReg[hul_pkg::CTRL_EN] && swapEff;
            request_to_send_n_out <= !(ctrlReg[hul_pkg::CTRL_EN] && !rxFull);
        end
    end

    // Read data, valid only in the cycle after the read strobe.
    always_ff @(posedge clk) begin
        if (rst) begin
            busRdata <= 32'h00000000;
        end else if (!busRd) begin
            busRdata <= 32'h00000000;
        end else if (hit(busAddr, hul_pkg::OFF_CTRL)) begin
            busRdata <= {28'h0000000, ctrlReg};
        end else if (hit(busAddr, hul_pkg::OFF_BAUD)) begin
            busRdata <= {11'h000, osrReg, divReg};
        end else if (hit(busAddr, hul_pkg::OFF_GAP)) begin
            busRdata <= {8'h00, wakeReg, rxToReg, txGapReg};
        end else if (hit(busAddr, hul_pkg::OFF_RXDATA)) begin
            busRdata <= {24'h000000, rxHold};
        end else if (hit(busAddr, hul_pkg::OFF_STATUS)) begin
            busRdata <= {26'h0000000, txBusy || !txState[0], txFull, rxFull, errFrm, errOvr, errTo};
        end else begin
            busRdata <= 32'h00000000;
        end
    end
endmodule // hul_top
`default_nettype wire

// ===== hul_top_sva.sv
// Port checker of the host serial link.
`timescale 1ns/1ns
`default_nettype none
module hul_top_chk (
    // Clock and resets
    input wire logic        clk,
    input wire logic        srst,
    input wire logic        power_on_reset_n_in,
    // Register port
    input wire logic        busRd,
    input wire logic [31:0] busRdata,
    // Pins
    input wire logic        pinAOut,
    input wire logic        pinAOe,
    input wire logic        pinBOut,
    input wire logic        pinBOe,
    input wire logic        request_to_send_n_out,
    input wire logic        hostWakeOut
);
    // Each assertion ties a pin or the read port to its documented cause.
    a_rdata_idle_zero: assert property (@(posedge clk) disable iff (srst)
        !$past(busRd) |-> busRdata == 32'h0) else $error("Read data outside answer cycle.");
    a_sync_reset_out: assert property (@(posedge clk) disable iff (!power_on_reset_n_in) srst |=>
        pinAOut && pinBOut && !pinAOe && !pinBOe && request_to_send_n_out && !hostWakeOut)
        else $error("Outputs not idle after reset.");
    a_por_level_hold: assert property (@(posedge clk) disable iff (srst) !power_on_reset_n_in |->
        request_to_send_n_out && !pinAOe && !pinBOe && !hostWakeOut) else $error("Active during reset.");
    a_settle_hold: assert property (@(posedge clk) disable iff (srst) $rose(power_on_reset_n_in) |->
        (request_to_send_n_out && !pinAOe && !pinBOe) [*8]) else $error("Reset ended early.");
    a_oe_exclusive: assert property (@(posedge clk) disable iff (srst)
        !(pinAOe && pinBOe)) else $error("Both pins driven.");
    a_pins_same: assert property (@(posedge clk) disable iff (srst)
        pinAOut == pinBOut) else $error("Pins carry different transmit levels.");
    a_start_driven: assert property (@(posedge clk) disable iff (srst)
        $fell(pinAOut) |-> pinAOe || pinBOe) else $error("Start bit on undriven pin.");
    a_bit_length: assert property (@(posedge clk) disable iff (srst)
        $fell(pinAOut) |=> !pinAOut [*4]) else $error("Low bit too short.");
endmodule // hul_top_chk
bind hul_top hul_top_chk chk (.clk(clk), .srst(srst), .power_on_reset_n_in(power_on_reset_n_in),
    .busRd(busRd), .busRdata(busRdata), .pinAOut(pinAOut), .pinAOe(pinAOe), .pinBOut(pinBOut),
    .pinBOe(pinBOe), .request_to_send_n_out(request_to_send_n_out), .hostWakeOut(hostWakeOut));
`default_nettype wire

// ===== hul_host_model.sv
// Behavioural host serial port at the far side of the link.
`timescale 1ns/1ns
`default_nettype none
module hul_host_model #(
    parameter int BIT = 16
) (
    input  wire logic clk,
    input  wire logic rxLine,
    output logic      txLine
);
    logic [7:0] lastByte = 8'h00;
    logic [7:0] shiftIn = 8'h00;
    int         gotCount = 0;
    int         cyc = 0;
    int         startCyc = 0;
    int         prevStart = 0;

    // The line idles at the mark level and counts cycles for gap timing.
    initial txLine = 1'b1;
    always @(posedge clk) cyc <= cyc + 1;

    // Sends one character; a zero stop bit makes a broken frame.
    task automatic sendChar(input logic [7:0] d, input logic stopBit);
        logic [9:0] frame;
        frame = {stopBit, d, 1'b0};
        for (int k = 0; k < 10; k++) begin
            @(posedge clk);
            txLine <= frame[k];
            repeat (BIT - 1) @(posedge clk);
        end
        @(posedge clk);
        txLine <= 1'b1;
    endtask

    // Decodes the device's characters by sampling mid-bit.
    initial begin
        forever begin
            @(posedge clk);
            if (rxLine === 1'b0) begin
                prevStart = startCyc;
                startCyc = cyc;
                repeat (BIT / 2) @(posedge clk);
                for (int k = 0; k < 8; k++) begin
                    repeat (BIT) @(posedge clk);
                    shiftIn = {rxLine, shiftIn[7:1]};
                end
                repeat (BIT) @(posedge clk);
                lastByte = shiftIn;
                gotCount++;
            end
        end
    end
endmodule // hul_host_model
`default_nettype wire

// ===== hul_top_tb_top.sv
// Self-checking testbench of the host serial link.
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin fail_count++; $display("BAD t=%0t %h %h", $time, g, e); end end
module hul_top_tb_top;
    localparam int BIT = 16;
    logic        clk = 1'b0;
    logic        srst = 1'b1;
    logic        porN = 1'b0;
    logic [7:0]  busAddr = 8'h00;
    logic [31:0] busWdata = 32'h0;
    logic        busWr = 1'b0;
    logic        busRd = 1'b0;
    logic        ctsN = 1'b1;
    logic [31:0] rdv;
    logic [7:0]  b;
    wire logic [31:0] busRdata;
    wire logic   aOut, aOe, bOut, bOe, rtsN, wake, hostTx;
    int          fail_count = 0;
    int          n_checks = 0;
    int          seed = 38;
    int          cnt;

    // Clock, device and far-side host.
    always #10 clk = ~clk;
    hul_top #(.SETTLE_CYCLES(8), .alternate_serial_port(1'b1)) uut (.clk(clk), .srst(srst),
        .power_on_reset_n_in(porN), .busAddr(busAddr), .busWdata(busWdata), .busWr(busWr), .busRd(busRd),
        .busRdata(busRdata), .pinAIn(bOe ? hostTx : 1'b1), .pinAOut(aOut), .pinAOe(aOe),
        .pinBIn(bOe ? 1'b1 : hostTx), .pinBOut(bOut), .pinBOe(bOe), .clear_to_send_n_in(ctsN),
        .request_to_send_n_out(rtsN), .hostWakeOut(wake));
    hul_host_model #(.BIT(BIT)) host (.clk(clk), .rxLine(aOe ? aOut : bOe ? bOut : 1'b1), .txLine(hostTx));

    // Bus cycles and settled waiting.
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        busAddr <= a;
        busWdata <= d;
        busWr <= 1'b1;
        @(posedge clk);
        busWr <= 1'b0;
        tick(1);
    endtask
    task automatic rd(input logic [7:0] a);
        busAddr <= a;
        busRd <= 1'b1;
        tick(1);
        busRd <= 1'b0;
        rdv = busRdata;
        tick(1);
    endtask
    task automatic waitTx(input int old);
        for (int i = 0; i < 5000 && host.gotCount == old; i++) tick(1);
        if (host.gotCount == old) fail_count++;
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    initial begin
        tick(40000);
        fail_count++;
        end_of_test();
    end

    // Main sequence of scenarios.
    initial begin
        tick(10);
        srst <= 1'b0;
        tick(2);
        porN <= 1'b1;
        tick(16);
        rd(hul_pkg::OFF_CTRL);
        `CHK(rdv, 32'h0)
        rd(hul_pkg::OFF_BAUD);
        `CHK(rdv, 32'h000E001F)
        rd(hul_pkg::OFF_GAP);
        `CHK(rdv, 32'h00010C03)
        rd(8'h20);
        `CHK(rdv, 32'h0)
        $display("test reset values done");
        wr(hul_pkg::OFF_BAUD, 32'h00080002);
        wr(hul_pkg::OFF_GAP, 32'h00010C04);
        wr(hul_pkg::OFF_CTRL, 32'h1);
        for (int i = 0; i < 4; i++) begin
            b = (i == 0) ? 8'h00 : (i == 1) ? 8'hFF : 8'($random(seed));
            cnt = host.gotCount;
            wr(hul_pkg::OFF_TXDATA, {23'h0, 1'b1, b});
            waitTx(cnt);
            `CHK(host.lastByte, b)
            if (i > 0) `CHK(host.startCyc - host.prevStart >= 50 * BIT, 1'b1)
        end
        $display("test transmit and gap done");
        b = 8'($random(seed));
        host.sendChar(b, 1'b1);
        tick(BIT);
        rd(hul_pkg::OFF_STATUS);
        `CHK(rdv[3:0], 4'h8)
        rd(hul_pkg::OFF_RXDATA);
        `CHK(rdv[7:0], b)
        tick(124 * BIT);
        rd(hul_pkg::OFF_STATUS);
        `CHK(rdv[0], 1'b1)
        wr(hul_pkg::OFF_STATUS, 32'h1);
        rd(hul_pkg::OFF_STATUS);
        `CHK(rdv[0], 1'b0)
        host.sendChar(b, 1'b1);
        host.sendChar(~b, 1'b1);
        tick(BIT);
        rd(hul_pkg::OFF_STATUS);
        `CHK(rdv[1], 1'b1)
        rd(hul_pkg::OFF_RXDATA);
        `CHK(rdv[7:0], b)
        host.sendChar(8'h5A, 1'b0);
        tick(BIT);
        rd(hul_pkg::OFF_STATUS);
        `CHK(rdv[3:1], 3'b011)
        wr(hul_pkg::OFF_STATUS, 32'h7);
        $display("test receive errors done");
        wr(hul_pkg::OFF_CTRL, 32'h3);
        tick(2);
        `CHK(rtsN, 1'b0)
        cnt = host.gotCount;
        wr(hul_pkg::OFF_TXDATA, {23'h0, 1'b1, b});
        tick(20 * BIT);
        `CHK(host.gotCount, cnt)
        ctsN <= 1'b0;
        waitTx(cnt);
        `CHK(host.lastByte, b)
        host.sendChar(8'h3C, 1'b1);
        tick(BIT);
        `CHK(rtsN, 1'b1)
        rd(hul_pkg::OFF_RXDATA);
        tick(2);
        `CHK(rtsN, 1'b0)
        $display("test flow control done");
        wr(hul_pkg::OFF_CTRL, 32'hD);
        cnt = host.gotCount;
        wr(hul_pkg::OFF_TXDATA, {23'h0, 1'b1, ~b});
        waitTx(cnt);
        `CHK(host.lastByte, ~b)
        `CHK(wake, 1'b1)
        tick(BIT);
        `CHK(wake, 1'b0)
        host.sendChar(b, 1'b1);
        tick(BIT);
        rd(hul_pkg::OFF_RXDATA);
        `CHK(rdv[7:0], b)
        srst <= 1'b1;
        tick(2);
        srst <= 1'b0;
        rd(hul_pkg::OFF_CTRL);
        `CHK(rdv, 32'h0)
        $display("test swap wake reset done");
        end_of_test();
    end
endmodule // hul_top_tb_top
`default_nettype wire
